// File: hdl/power_state_device.sv
`timescale 1ns/1ps
`default_nettype none
module power_state_device
  import pwr_ctl_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Power-up reset, active low
  pwr_ctl_if.device ctl, // Reset pin and control port
  input wire logic watchdogFire, // Internal watchdog pulse
  output logic [1:0] powerState, // Current power state
  output logic processorRun, // Internal processor running
  output logic analogEnable, // Codec and telecom supply on
  output logic [7:0] interfaceSel, // Selected interface
  output logic [7:0] configOut // Config register contents
);
  typedef struct packed {
    pwr_state_t st;
    logic [7:0] moduleMode;
    logic [7:0] ifSel;
    logic [7:0] cfg;
    logic [7:0] rdData;
    logic wdHold;
  } dev_state_t;
  dev_state_t state_reg;
  dev_state_t state_next;
  logic releasePulse;
  logic cntLoad;
  logic [7:0] rstCount;

  reset_counter #(.WIDTH(8)) u_cnt (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .releaseEvent(releasePulse),
    .load(cntLoad),
    .loadValue(ctl.wrData),
    .count(rstCount)
  );

  // Behaviour notes for whoever integrates this end
  // Reset state
  // The pin is a level, not an edge
  // Held high, the device stays in reset
  // No upper bound on how long it stays there
  // Release happens on the first edge with pin low and no watchdog hold bit set
  // Release reloads the mode, selection and config defaults
  // Release also bumps the event counter
  // Power-up reset
  // The async reset parks the state machine and zeroes the counter
  // Counting waits for the pin to go low
  // So power-up counts as one release
  // Watchdog
  // A watchdog pulse only acts while running
  // It parks the machine for two cycles
  // The hold bit blocks an instant re-release
  // That keeps the counter pulse clean
  // The watchdog release is counted like any other
  // Shutdown
  // Entered by the mode command only
  // The processor stops, so strobes are ignored
  // Read data freezes at its last value
  // Only the pin can wake the device
  // A watchdog cannot fire while stopped
  // Inactive
  // Entered by a zero interface selection
  // Analog side and telecom supply go off
  // Mode and config fall back to defaults
  // Port access keeps working here
  // Any nonzero selection brings it back
  // Same nonzero selection while active is a no-op
  // Mode command from inactive still shuts down
  // Register port
  // Writes and reads are one-cycle strobes
  // Read data lands one cycle after the strobe
  // Read data holds until the next accepted read
  // Unknown read addresses return zero
  // Unknown write addresses are dropped
  // Counter preset
  // Goes straight to the counter module
  // A same-cycle release adds one to the preset
  // So no release event is ever lost
  // Limitations
  // Only one mode code is decoded
  // Other mode values are stored, not acted on
  // No supply monitoring inside this end
  // Power sequencing is the host's job
  // Ringing cadence is the host's job too
  // Trade-offs
  // One registered state record keeps timing flat
  // Combinational strobes keep access latency short
  // Defaults live in the package, not here
  // Hazards
  // Pin high in the same cycle as a write
  // The pin wins; register writes are undone at release, a counter preset is kept
  // Watchdog in the same cycle as a write
  // The watchdog wins; register writes are undone at release, a counter preset is kept
  // Both are deliberate: reset must dominate
  // Outputs
  // Power state is the raw state code
  // Processor run mirrors port access
  // Analog enable only in the active state
  // Selection and config come from registers
  // Port access only while the processor runs
  logic access;
  assign access = (state_reg.st == ST_ACTIVE) || (state_reg.st == ST_INACTIVE);
  assign cntLoad = access && ctl.wrStrobe && (ctl.addr == ADDR_RST_CNT);

  // Power state machine and register file
  always_comb begin
    state_next = state_reg;
    releasePulse = 1'b0;
    state_next.wdHold = 1'b0;
    case (state_reg.st)
      ST_RESET: begin
        if (!ctl.moduleReset && !state_reg.wdHold) begin
          state_next.st = ST_ACTIVE;
          state_next.moduleMode = MODE_DEFAULT;
          state_next.ifSel = IFSEL_DEFAULT;
          state_next.cfg = CFG_DEFAULT;
          releasePulse = 1'b1;
        end
      end
      ST_ACTIVE, ST_INACTIVE: begin
        if (ctl.wrStrobe) begin
          case (ctl.addr)
            ADDR_MODE: begin
              state_next.moduleMode = ctl.wrData;
              if (ctl.wrData == MODE_SHUTDOWN) begin
                state_next.st = ST_SHUTDOWN;
              end
            end
            ADDR_IFSEL: begin
              if (ctl.wrData == IFSEL_INACTIVE) begin
                state_next.st = ST_INACTIVE;
                state_next.ifSel = IFSEL_INACTIVE;
                state_next.moduleMode = MODE_DEFAULT;
                state_next.cfg = CFG_DEFAULT;
              end else if (ctl.wrData != state_reg.ifSel) begin
                state_next.st = ST_ACTIVE;
                state_next.ifSel = ctl.wrData;
              end
            end
            ADDR_CFG: state_next.cfg = ctl.wrData;
            default: ;
          endcase
        end
        if (ctl.rdStrobe) begin
          case (ctl.addr)
            ADDR_MODE: state_next.rdData = state_reg.moduleMode;
            ADDR_IFSEL: state_next.rdData = state_reg.ifSel;
            ADDR_CFG: state_next.rdData = state_reg.cfg;
            ADDR_RST_CNT: state_next.rdData = rstCount;
            default: state_next.rdData = 8'h00;
          endcase
        end
        if (watchdogFire) begin
          state_next.st = ST_RESET;
          state_next.wdHold = 1'b1;
        end
      end
      ST_SHUTDOWN: begin
        state_next.st = ST_SHUTDOWN;
      end
      default: state_next.st = ST_RESET;
    endcase
    // Pin high overrides every next state, shutdown included; same-cycle writes still land
    if (ctl.moduleReset) begin
      state_next.st = ST_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{st: ST_RESET, moduleMode: MODE_DEFAULT, ifSel: IFSEL_DEFAULT,
                     cfg: CFG_DEFAULT, rdData: 8'h00, wdHold: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from state
  assign ctl.rdData = state_reg.rdData;
  assign powerState = state_reg.st;
  assign processorRun = access;
  assign analogEnable = (state_reg.st == ST_ACTIVE);
  assign interfaceSel = state_reg.ifSel;
  assign configOut = state_reg.cfg;
endmodule
`default_nettype wire

// File: inc/pwr_ctl_pkg.sv
package pwr_ctl_pkg;
  // Register addresses on the module's control port
  localparam logic [6:0] ADDR_MODE = 7'h01;
  localparam logic [6:0] ADDR_IFSEL = 7'h02;
  localparam logic [6:0] ADDR_RST_CNT = 7'h3F;
  localparam logic [6:0] ADDR_CFG = 7'h03;
  // Command values
  localparam logic [7:0] MODE_SHUTDOWN = 8'h01;
  localparam logic [7:0] IFSEL_INACTIVE = 8'h00;
  // Factory defaults
  localparam logic [7:0] MODE_DEFAULT = 8'h00;
  localparam logic [7:0] IFSEL_DEFAULT = 8'h01;
  localparam logic [7:0] CFG_DEFAULT = 8'h00;
  localparam logic [7:0] RST_CNT_INIT = 8'h00;
  // Host-side register map
  localparam logic [3:0] HOST_CTRL = 4'h0;
  localparam logic [3:0] HOST_ADDR = 4'h4;
  localparam logic [3:0] HOST_WDATA = 4'h8;
  localparam logic [3:0] HOST_RDATA = 4'hC;
  localparam int HOST_CTRL_RESET_BIT = 0;
  localparam int HOST_CTRL_WR_BIT = 1;
  localparam int HOST_CTRL_RD_BIT = 2;
  localparam int HOST_CTRL_POWER_BIT = 3;
  // Power-up hold time before release, in ns
  localparam int POWER_HOLD_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int POWER_HOLD_CYCLES = (POWER_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Device power states
  typedef enum logic [1:0] {
    ST_RESET,
    ST_ACTIVE,
    ST_INACTIVE,
    ST_SHUTDOWN
  } pwr_state_t;
endpackage

// File: inc/pwr_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pwr_ctl_if;
  logic moduleReset;
  logic [6:0] addr;
  logic [7:0] wrData;
  logic wrStrobe;
  logic rdStrobe;
  logic [7:0] rdData;
  modport device (input moduleReset, addr, wrData, wrStrobe, rdStrobe, output rdData);
  modport host (output moduleReset, addr, wrData, wrStrobe, rdStrobe, input rdData);
endinterface
`default_nettype wire

// File: hdl/reset_counter.sv
`timescale 1ns/1ps
`default_nettype none
module reset_counter
  import pwr_ctl_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic releaseEvent, // One-cycle pulse on reset release
  input wire logic load, // Host preset strobe
  input wire logic [WIDTH-1:0] loadValue, // Preset value
  output logic [WIDTH-1:0] count // Current count
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } cnt_state_t;
  cnt_state_t state_reg;
  cnt_state_t state_next;

  // A same-cycle release adds one to the preset so no release is lost
  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.cnt = loadValue;
    end
    if (releaseEvent) begin
      state_next.cnt = (load ? loadValue : state_reg.cnt) + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.cnt;
endmodule
`default_nettype wire

// File: hdl/power_state_host.sv
`timescale 1ns/1ps
`default_nettype none
module power_state_host
  import pwr_ctl_pkg::*;
#(
  parameter int HOLD_CYCLES = POWER_HOLD_CYCLES
) (
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [3:0] swAddr, // Software address
  input wire logic [31:0] swWrData, // Software write data
  input wire logic swWrite, // Software write strobe
  input wire logic swRead, // Software read strobe
  output logic [31:0] swRdData, // Read data, cycle after read
  pwr_ctl_if.host ctl // Reset pin and control port
);
  typedef struct packed {
    logic resetReq;
    logic powerOk;
    logic [15:0] holdCnt;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic rdPend;
    logic [7:0] rcap;
    logic [31:0] swRd;
  } host_state_t;
  host_state_t state_reg;
  host_state_t state_next;

  // Software command decode and reset sequencing
  always_comb begin
    state_next = state_reg;
    state_next.wr = 1'b0;
    state_next.rd = 1'b0;
    state_next.rdPend = state_reg.rd;
    if (state_reg.rdPend) begin
      state_next.rcap = ctl.rdData;
    end
    if (state_reg.holdCnt != 16'h0000) begin
      state_next.holdCnt = state_reg.holdCnt - 16'h0001;
    end
    if (swWrite) begin
      case (swAddr)
        HOST_CTRL: begin
          state_next.resetReq = swWrData[HOST_CTRL_RESET_BIT];
          state_next.powerOk = swWrData[HOST_CTRL_POWER_BIT];
          // Writes blocked while supply is not good
          state_next.wr = swWrData[HOST_CTRL_WR_BIT] && swWrData[HOST_CTRL_POWER_BIT];
          state_next.rd = swWrData[HOST_CTRL_RD_BIT];
        end
        HOST_ADDR: state_next.addr = swWrData[6:0];
        HOST_WDATA: state_next.wdata = swWrData[7:0];
        default: ;
      endcase
    end
    // Ringing cadence is left to software via the config register
    state_next.swRd = 32'h0000_0000;
    if (swRead) begin
      case (swAddr)
        HOST_CTRL: state_next.swRd = {28'h0, state_reg.powerOk, 2'b00, ctl.moduleReset};
        HOST_ADDR: state_next.swRd = {25'h0, state_reg.addr};
        HOST_WDATA: state_next.swRd = {24'h0, state_reg.wdata};
        HOST_RDATA: state_next.swRd = {24'h0, state_reg.rcap};
        default: state_next.swRd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.resetReq <= 1'b1;
      state_reg.holdCnt <= 16'(HOLD_CYCLES);
    end else begin
      state_reg <= state_next;
    end
  end

  // Pin high while requested or hold time running
  assign ctl.moduleReset = state_reg.resetReq || (state_reg.holdCnt != 16'h0000);
  assign ctl.addr = state_reg.addr;
  assign ctl.wrData = state_reg.wdata;
  assign ctl.wrStrobe = state_reg.wr && !ctl.moduleReset;
  assign ctl.rdStrobe = state_reg.rd && !ctl.moduleReset;
  assign swRdData = state_reg.swRd;
endmodule
`default_nettype wire

// File: dv/pwr_ctl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pwr_ctl_asserts
  import pwr_ctl_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic moduleReset, // Pin
  input wire logic [6:0] addr, // Address
  input wire logic [7:0] wrData, // Write data
  input wire logic wrStrobe, // Write
  input wire logic rdStrobe, // Read
  input wire logic [7:0] rdData, // Read data
  input wire logic watchdogFire, // Watchdog
  input wire logic [1:0] powerState, // State
  input wire logic processorRun, // Processor
  input wire logic analogEnable, // Analog on
  input wire logic [7:0] interfaceSel, // Selection
  input wire logic [7:0] configOut // Config
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Accesses only count while running and not being reset
  logic live;
  assign live = powerState inside {2'd1, 2'd2} && !moduleReset && !watchdogFire;
  pin_wins_a:
    assert property ((moduleReset || watchdogFire) |=> powerState == 2'd0) else $error("no reset");
  release_defaults_a:
    assert property (powerState == 2'd0 && !moduleReset && !watchdogFire && !$past(watchdogFire)
      |=> powerState == 2'd1
      && interfaceSel == IFSEL_DEFAULT && configOut == CFG_DEFAULT) else $error("bad release");
  sleep_entry_a:
    assert property (wrStrobe && addr == ADDR_MODE && wrData == MODE_SHUTDOWN && live
      |=> powerState == 2'd3 && !processorRun) else $error("no shutdown");
  sleep_hold_a:
    assert property (powerState == 2'd3 && !moduleReset && !watchdogFire
      |=> powerState == 2'd3 && !processorRun && $stable(rdData)) else $error("left shutdown");
  go_inactive_a:
    assert property (wrStrobe && addr == ADDR_IFSEL && wrData == IFSEL_INACTIVE && live
      |=> powerState == 2'd2 && !analogEnable && configOut == CFG_DEFAULT) else $error("no idle");
  leave_inactive_a:
    assert property (powerState == 2'd2 && wrStrobe && addr == ADDR_IFSEL && wrData != 8'h00
      && live |=> powerState == 2'd1 && interfaceSel == $past(wrData)) else $error("stuck idle");
  inactive_access_a:
    assert property (rdStrobe && addr == ADDR_IFSEL && live
      |=> rdData == $past(interfaceSel) && processorRun) else $error("read lost");
  analog_off_a:
    assert property (powerState != 2'd1 |-> !analogEnable) else $error("analog on");
  power_hold_a:
    assert property ($rose(reset_n) |-> moduleReset [*4]) else $error("early release");
endmodule
`default_nettype wire

// File: dv/power_state_reset_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_state_reset_control_tb import pwr_ctl_pkg::*;;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] swAddr = 4'h0;
  logic [31:0] swWrData = 32'h0;
  logic swWrite = 1'b0;
  logic swRead = 1'b0;
  logic watchdogFire = 1'b0;
  logic [31:0] swRdData;
  logic [1:0] powerState;
  logic processorRun;
  logic analogEnable;
  logic [7:0] interfaceSel;
  logic [7:0] configOut;
  logic [7:0] seed = 8'h5F;
  logic [7:0] got;
  logic [7:0] val;
  int miscompares = 0;
  int nTests = 0;
  pwr_ctl_if ctl ();
  power_state_host #(.HOLD_CYCLES(4)) u_power_state_host (.core_clk(core_clk),
    .reset_n(reset_n), .swAddr(swAddr), .swWrData(swWrData), .swWrite(swWrite),
    .swRead(swRead), .swRdData(swRdData), .ctl(ctl.host));
  power_state_device u_power_state_device (.core_clk(core_clk), .reset_n(reset_n),
    .ctl(ctl.device), .watchdogFire(watchdogFire), .powerState(powerState),
    .processorRun(processorRun), .analogEnable(analogEnable), .interfaceSel(interfaceSel),
    .configOut(configOut));
  pwr_ctl_asserts u_pwr_ctl_asserts (.core_clk(core_clk), .reset_n(reset_n),
    .moduleReset(ctl.moduleReset), .addr(ctl.addr), .wrData(ctl.wrData),
    .wrStrobe(ctl.wrStrobe), .rdStrobe(ctl.rdStrobe), .rdData(ctl.rdData),
    .watchdogFire(watchdogFire), .powerState(powerState), .processorRun(processorRun),
    .analogEnable(analogEnable), .interfaceSel(interfaceSel), .configOut(configOut));
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  // Random source, repeatable from its fixed start
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Strobe drops on the next edge, so a following call never re-drives it in the same step
  task automatic swWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    swAddr <= a;
    swWrData <= d;
    swWrite <= 1'b1;
    @(posedge core_clk);
    swWrite <= 1'b0;
  endtask
  task automatic swRd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    swAddr <= a;
    swRead <= 1'b1;
    @(posedge core_clk);
    swRead <= 1'b0;
    #1 d = swRdData;
  endtask
  // Device accesses go through the host's staging registers, power-ok kept set
  task automatic devWr(input logic [6:0] a, input logic [7:0] d);
    swWr(HOST_ADDR, {25'h0, a});
    swWr(HOST_WDATA, {24'h0, d});
    swWr(HOST_CTRL, 32'hA);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic devRd(input logic [6:0] a, output logic [7:0] d);
    logic [31:0] r;
    swWr(HOST_ADDR, {25'h0, a});
    swWr(HOST_CTRL, 32'hC);
    repeat (6) @(posedge core_clk);
    swRd(HOST_RDATA, r);
    d = r[7:0];
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    swWr(HOST_CTRL, 32'h8);
    repeat (4) @(posedge core_clk);
    devRd(ADDR_RST_CNT, got); check(got, 8'h01);
    devRd(ADDR_IFSEL, got); check(got, IFSEL_DEFAULT);
    devRd(ADDR_MODE, got); check(got, MODE_DEFAULT);
    $display("defaults test done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      val = (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : seed);
      devWr(ADDR_RST_CNT, val);
      devRd(ADDR_RST_CNT, got); check(got, val);
    end
    @(posedge core_clk) watchdogFire <= 1'b1;
    @(posedge core_clk) watchdogFire <= 1'b0;
    repeat (4) @(posedge core_clk);
    devRd(ADDR_RST_CNT, got); check(got, val + 8'h01);
    val = got;
    $display("counter test done");
    seed = lfsr(seed);
    devWr(ADDR_CFG, {seed[7:1], 1'b1});
    devRd(ADDR_CFG, got); check(got, {seed[7:1], 1'b1});
    devWr(ADDR_IFSEL, IFSEL_INACTIVE);
    check(powerState, ST_INACTIVE);
    check({processorRun, analogEnable}, 2'b10);
    devRd(ADDR_CFG, got); check(got, CFG_DEFAULT);
    seed = lfsr(seed);
    devWr(ADDR_IFSEL, {seed[7:1], 1'b1});
    check(powerState, ST_ACTIVE);
    devRd(ADDR_IFSEL, got); check(got, {seed[7:1], 1'b1});
    check(interfaceSel, {seed[7:1], 1'b1});
    // Write attempt with power-ok low must never reach the device
    swWr(HOST_ADDR, {25'h0, ADDR_CFG});
    swWr(HOST_WDATA, 32'h55);
    swWr(HOST_CTRL, 32'h2);
    repeat (4) @(posedge core_clk);
    check(configOut, CFG_DEFAULT);
    swWr(HOST_CTRL, 32'h8);
    $display("inactive test done");
    devWr(ADDR_MODE, MODE_SHUTDOWN);
    check({powerState, processorRun}, {ST_SHUTDOWN, 1'b0});
    devWr(ADDR_CFG, 8'h3C);
    devRd(ADDR_MODE, got); check(got, {seed[7:1], 1'b1});
    check(powerState, ST_SHUTDOWN);
    swWr(HOST_CTRL, 32'h9);
    repeat (4) @(posedge core_clk);
    check(powerState, ST_RESET);
    swWr(HOST_CTRL, 32'h8);
    repeat (4) @(posedge core_clk);
    check(powerState, ST_ACTIVE);
    devRd(ADDR_RST_CNT, got); check(got, val + 8'h01);
    devRd(ADDR_CFG, got); check(got, CFG_DEFAULT);
    $display("shutdown test done");
    end_sim;
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    miscompares++;
    end_sim;
  end
endmodule
`default_nettype wire
